// ===== design/sop_serial_out.sv
// Serial output stage: four lanes, bit clock, frame clock, test patterns.
// Assumes CLK is the sample clock and LINK_CLK runs at six ticks per serial
// bit; register and configuration inputs come from CLK-domain logic.
`timescale 1ns/1ps

module sop_serial_out
    import sop_pkg::*;
#(
    parameter int CLK_KHZ = SOP_CLK_KHZ
) (
    // Sample clock domain
    input  wire logic                     CLK,
    input  wire logic                     NRST,
    input  wire sop_pkg::sop_samples_t    SAMPLES,
    input  wire sop_pkg::sop_cfg_s        CFG,
    // Register port
    input  wire logic [7:0]               REG_ADDR,
    input  wire logic [7:0]               REG_WDATA,
    input  wire logic                     REG_WE,
    output logic      [7:0]               REG_RDATA,
    output logic                          RATE_OK,
    // Link side
    input  wire logic                     LINK_CLK,
    output logic      [SOP_LANES-1:0]     LANE_POS,
    output logic      [SOP_LANES-1:0]     LANE_NEG,
    output logic                          BIT_CLOCK_OUT_POS,
    output logic                          BIT_CLOCK_OUT_NEG,
    output logic                          FRAME_CLOCK_OUT_POS,
    output logic                          FRAME_CLOCK_OUT_NEG
);
    import sop_pkg::*;

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [3:0] len_of(input logic [1:0] r);
        case (r)
            SOP_RES_8:  len_of = SOP_LEN_8;
            SOP_RES_12: len_of = SOP_LEN_12;
            SOP_RES_14: len_of = SOP_LEN_14;
            default:    len_of = SOP_LEN_10;
        endcase
    endfunction

    function automatic logic [13:0] mask_of(input logic [1:0] r);
        mask_of = (14'h0001 << len_of(r)) - 14'h0001;
    endfunction

    function automatic logic [13:0] msb_of(input logic [1:0] r);
        msb_of = 14'h0001 << (len_of(r) - 4'h1);
    endfunction

    // Ten converter bits placed into the selected length
    function automatic logic [13:0] fit_of(input logic [9:0] d, input logic [1:0] r);
        case (r)
            SOP_RES_8:  fit_of = {6'h00, d[9:2]};
            SOP_RES_12: fit_of = {2'h0, d, 2'h0};
            SOP_RES_14: fit_of = {d, 4'h0};
            default:    fit_of = {4'h0, d};
        endcase
    endfunction

    function automatic logic [13:0] rev_of(input logic [13:0] w, input logic [1:0] r);
        int n;
        rev_of = 14'h0000;
        n = int'(len_of(r));
        for (int i = 0; i < SOP_WORD_BITS; i++) begin
            if (i < n) begin
                rev_of[n-1-i] = w[i];
            end
        end
    endfunction

    function automatic logic [13:0] mix_of(input logic [1:0] r);
        case (r)
            SOP_RES_8:  mix_of = SOP_MIX_8;
            SOP_RES_12: mix_of = SOP_MIX_12;
            SOP_RES_14: mix_of = SOP_MIX_14;
            default:    mix_of = SOP_MIX_10;
        endcase
    endfunction

    function automatic logic [13:0] user_of(input logic [15:0] u, input logic [1:0] r);
        logic [15:0] t;
        t = u >> (5'h10 - {1'b0, len_of(r)});
        user_of = t[13:0];
    endfunction

    // Ten steps of a generator: new bits feed the LSB, the bit below the top goes out
    function automatic logic [18:0] step_sh(input logic [8:0] s);
        logic [8:0] r;
        logic [9:0] o;
        logic       b;
        r = s;
        o = 10'h000;
        for (int i = 0; i < SOP_BITS_SAMPLE; i++) begin
            b = r[8] ^ r[SOP_PRBS_SH_TAP];
            o = {o[8:0], r[7]};
            r = {r[7:0], b};
        end
        step_sh = {o, r};
    endfunction

    function automatic logic [32:0] step_lg(input logic [22:0] s);
        logic [22:0] r;
        logic [9:0]  o;
        logic        b;
        r = s;
        o = 10'h000;
        for (int i = 0; i < SOP_BITS_SAMPLE; i++) begin
            b = r[22] ^ r[SOP_PRBS_LG_TAP];
            o = {o[8:0], r[21]};
            r = {r[21:0], b};
        end
        step_lg = {o, r};
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] u1a_q, u1b_q, u2a_q, u2b_q;
    logic [7:0] rdata_q;
    logic       rate_ok_q;

    wire sel_u1a = (REG_ADDR == SOP_ADDR_U1A);
    wire sel_u1b = (REG_ADDR == SOP_ADDR_U1B);
    wire sel_u2a = (REG_ADDR == SOP_ADDR_U2A);
    wire sel_u2b = (REG_ADDR == SOP_ADDR_U2B);
    logic [7:0] rdata_d;
    always_comb begin
        if (sel_u1a) begin
            rdata_d = u1a_q;
        end else if (sel_u1b) begin
            rdata_d = u1b_q;
        end else if (sel_u2a) begin
            rdata_d = u2a_q;
        end else if (sel_u2b) begin
            rdata_d = u2b_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    // Rate window depends on CLK_KHZ and CFG.low_rate; reported so software can check it
    wire rate_ok_d = (CLK_KHZ >= (CFG.low_rate ? SOP_MIN_KSPS_LOW : SOP_MIN_KSPS))
                   && (CLK_KHZ * SOP_BITS_SAMPLE <= SOP_MAX_KBPS);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            u1a_q     <= SOP_USER_RST;
            u1b_q     <= SOP_USER_RST;
            u2a_q     <= SOP_USER_RST;
            u2b_q     <= SOP_USER_RST;
            rdata_q   <= 8'h00;
            rate_ok_q <= 1'b0;
        end else begin
            u1a_q     <= (REG_WE && sel_u1a) ? REG_WDATA : u1a_q;
            u1b_q     <= (REG_WE && sel_u1b) ? REG_WDATA : u1b_q;
            u2a_q     <= (REG_WE && sel_u2a) ? REG_WDATA : u2a_q;
            u2b_q     <= (REG_WE && sel_u2b) ? REG_WDATA : u2b_q;
            rdata_q   <= rdata_d;
            rate_ok_q <= rate_ok_d;
        end
    end
    assign REG_RDATA = rdata_q;
    assign RATE_OK   = rate_ok_q;

    a_reg_unmapped: assert property (@(posedge CLK) disable iff (!NRST)
        !(sel_u1a || sel_u1b || sel_u2a || sel_u2b) |=> REG_RDATA == 8'h00)
        else $error("unmapped register read not zero");

    // ****************************************
    // Word builder (sample domain)
    // ****************************************
    logic        req_q, ack_s1_q, ack_s2_q, alt_q, ack_q;
    logic [8:0]  psh_q;
    logic [22:0] plg_q;
    sop_word_s   hold_q;
    logic [2:0]  phase_q;

    wire         launch = (req_q == ack_s2_q);
    wire [18:0]  sh_nx  = step_sh(psh_q);
    wire [32:0]  lg_nx  = step_lg(plg_q);
    wire [1:0]   res    = CFG.res;
    wire [13:0]  mask   = mask_of(res);
    wire [13:0]  msb    = msb_of(res);
    wire [13:0]  chk    = SOP_CHECKER & mask;
    wire         fmt_on = (CFG.mode == SOP_MODE_OFF) || (CFG.mode == SOP_MODE_MID)
                       || (CFG.mode == SOP_MODE_FS_POS) || (CFG.mode == SOP_MODE_FS_NEG)
                       || (CFG.mode == SOP_MODE_PRBS_LG) || (CFG.mode == SOP_MODE_PRBS_SH);

    logic [13:0] pat;
    always_comb begin
        case (CFG.mode)
            SOP_MODE_MID:     pat = msb;
            SOP_MODE_FS_POS:  pat = mask;
            SOP_MODE_FS_NEG:  pat = 14'h0000;
            SOP_MODE_CHECKER: pat = alt_q ? (~chk & mask) : chk;
            SOP_MODE_PRBS_LG: pat = fit_of(~lg_nx[32:23], res);
            SOP_MODE_PRBS_SH: pat = fit_of(sh_nx[18:9], res);
            SOP_MODE_WORD_TG: pat = alt_q ? 14'h0000 : mask;
            SOP_MODE_USER:    pat = alt_q ? user_of({u2a_q, u2b_q}, res)
                                          : user_of({u1a_q, u1b_q}, res);
            SOP_MODE_BIT_TG:  pat = chk;
            SOP_MODE_SYNC:    pat = (14'h0001 << (len_of(res) >> 1)) - 14'h0001;
            SOP_MODE_ONE_HI:  pat = msb;
            SOP_MODE_MIXED:   pat = mix_of(res);
            default:          pat = 14'h0000;
        endcase
    end

    // Per-lane formatting: data or pattern, code, inversion, bit order
    sop_lanes_t pre, words;
    always_comb begin
        for (int i = 0; i < SOP_LANES; i++) begin
            pre[i] = (CFG.mode == SOP_MODE_OFF) ? fit_of(SAMPLES[i], res) : pat;
            if (fmt_on && CFG.twos) begin
                pre[i] = pre[i] ^ msb;
            end
            words[i] = CFG.invert ? (~pre[i] & mask) : pre[i];
            if (CFG.lsb_first) begin
                words[i] = rev_of(words[i], res);
            end
        end
    end

    // Handshake launch: hold only changes after the link side has taken it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            req_q    <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            alt_q    <= 1'b0;
            psh_q    <= SOP_PRBS_SH_SEED;
            plg_q    <= SOP_PRBS_LG_SEED;
            hold_q   <= '0;
            phase_q  <= 3'h0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            phase_q  <= CFG.phase;
            if (launch) begin
                req_q        <= ~req_q;
                alt_q        <= ~alt_q;
                hold_q.res   <= res;
                hold_q.lanes <= words;
            end
            if (CFG.mode != SOP_MODE_PRBS_SH) begin
                psh_q <= SOP_PRBS_SH_SEED;
            end else if (launch) begin
                psh_q <= sh_nx[8:0];
            end
            if (CFG.mode != SOP_MODE_PRBS_LG) begin
                plg_q <= SOP_PRBS_LG_SEED;
            end else if (launch) begin
                plg_q <= lg_nx[22:0];
            end
        end
    end

    a_word_passthru: assert property (@(posedge CLK) disable iff (!NRST)
        (CFG.mode == SOP_MODE_OFF && !CFG.invert && !CFG.lsb_first && !CFG.twos && res == SOP_RES_10)
        |-> words[0] == {4'h0, SAMPLES[0]})
        else $error("lane word differs from sample");
    a_word_pad12: assert property (@(posedge CLK) disable iff (!NRST)
        (CFG.mode == SOP_MODE_OFF && !CFG.invert && !CFG.lsb_first && !CFG.twos && res == SOP_RES_12)
        |-> words[1] == {2'h0, SAMPLES[1], 2'h0})
        else $error("twelve bit word not zero padded");
    a_word_invert: assert property (@(posedge CLK) disable iff (!NRST)
        (CFG.mode == SOP_MODE_OFF && CFG.invert && !CFG.lsb_first && !CFG.twos && res == SOP_RES_10)
        |-> words[2] == {4'h0, ~SAMPLES[2]})
        else $error("inverted word wrong");
    a_short_seed: assert property (@(posedge CLK) disable iff (!NRST)
        (CFG.mode != SOP_MODE_PRBS_SH) |=> psh_q == 9'h0df)
        else $error("short generator not reseeded");
    a_short_first: assert property (@(posedge CLK) disable iff (!NRST)
        (CFG.mode == SOP_MODE_PRBS_SH && psh_q == 9'h0df && res == SOP_RES_10) |-> pat == 14'h037e)
        else $error("short sequence first word wrong");
    a_long_first: assert property (@(posedge CLK) disable iff (!NRST)
        (CFG.mode == SOP_MODE_PRBS_LG && plg_q == 23'h0a6e02 && res == SOP_RES_10) |-> pat == 14'h0359)
        else $error("long sequence first word wrong");
    a_hold_stable: assert property (@(posedge CLK) disable iff (!NRST)
        !launch |=> $stable(hold_q))
        else $error("hold word changed during crossing");

    // ****************************************
    // Link domain
    // ****************************************
    logic        lrst_s1_q, lrst_s2_q;
    logic        req_s1_q, req_s2_q;
    logic [2:0]  phs_s1_q, phs_s2_q;
    sop_word_s   pend_q, cur_q;
    logic [2:0]  tick_q;
    logic [3:0]  bit_q;
    logic [SOP_LANES-1:0] lane_q;
    logic        bclk_q, fclk_q;

    wire         lrst_n = lrst_s2_q;

    always_ff @(posedge LINK_CLK or negedge NRST) begin
        if (!NRST) begin
            lrst_s1_q <= 1'b0;
            lrst_s2_q <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            lrst_s2_q <= lrst_s1_q;
        end
    end

    wire [3:0]   len       = len_of(cur_q.res);
    wire         tick_end  = (tick_q == 3'(SOP_TICKS_BIT - 1));
    wire         frame_end = tick_end && (bit_q == len - 4'h1);
    wire         take      = (req_s2_q != ack_q);
    wire [3:0]   idx       = len - 4'h1 - bit_q;
    wire [3:0]   pos       = {1'b0, tick_q} + (bit_q[0] ? 4'(SOP_TICKS_BIT) : 4'h0);
    // Phase codes above four wrap round the bit clock period
    wire [5:0]   off_raw   = 6'(SOP_PH_DEF_TICKS) + 6'(SOP_PH_STEP_TCK) * {3'h0, phs_s2_q};
    wire [5:0]   off       = off_raw % 6'(SOP_BCLK_TICKS);
    wire [5:0]   rel       = ({2'h0, pos} + 6'(SOP_BCLK_TICKS) - off) % 6'(SOP_BCLK_TICKS);
    wire         bclk_d    = (rel < 6'(SOP_TICKS_BIT));
    wire         fclk_d    = (bit_q < (len >> 1));

    logic [SOP_LANES-1:0] lane_d;
    always_comb begin
        for (int i = 0; i < SOP_LANES; i++) begin
            lane_d[i] = cur_q.lanes[i][idx];
        end
    end

    always_ff @(posedge LINK_CLK or negedge lrst_n) begin
        if (!lrst_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_q    <= 1'b0;
            phs_s1_q <= 3'h0;
            phs_s2_q <= 3'h0;
            pend_q   <= '0;
            cur_q    <= '0;
            tick_q   <= 3'h0;
            bit_q    <= 4'h0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            phs_s1_q <= phase_q;
            phs_s2_q <= phs_s1_q;
            if (take) begin
                pend_q <= hold_q;
                ack_q  <= req_s2_q;
            end
            tick_q <= tick_end ? 3'h0 : tick_q + 3'h1;
            if (frame_end) begin
                bit_q <= 4'h0;
                cur_q <= pend_q;
            end else if (tick_end) begin
                bit_q <= bit_q + 4'h1;
            end
        end
    end

    // Pins: all outputs registered so that data, bit and frame clocks align
    always_ff @(posedge LINK_CLK or negedge lrst_n) begin
        if (!lrst_n) begin
            lane_q <= '0;
            bclk_q <= 1'b0;
            fclk_q <= 1'b0;
        end else begin
            lane_q <= lane_d;
            bclk_q <= bclk_d;
            fclk_q <= fclk_d;
        end
    end
    assign LANE_POS            = lane_q;
    assign LANE_NEG            = ~lane_q;
    assign BIT_CLOCK_OUT_POS   = bclk_q;
    assign BIT_CLOCK_OUT_NEG   = ~bclk_q;
    assign FRAME_CLOCK_OUT_POS = fclk_q;
    assign FRAME_CLOCK_OUT_NEG = ~fclk_q;

    a_frame_start: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
        (bit_q == 4'h0 && tick_q == 3'h0) |=> fclk_q)
        else $error("frame clock low at word start");
    a_frame_width: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
        $rose(fclk_q) |-> fclk_q [*8])
        else $error("frame clock high too short");
    a_bclk_half: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
        ($rose(bclk_q) && $stable(phs_s2_q)) |-> ##6 $fell(bclk_q))
        else $error("bit clock half period wrong");
    a_bclk_phase: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
        (phs_s2_q == 3'h0 && tick_q == 3'h3 && !bit_q[0]) |=> $rose(bclk_q))
        else $error("bit clock not at default phase");

endmodule

// ===== design/sop_pkg.sv
// Constants, codes and carrier types for the serial output stage.
// Assumes one sample clock domain and one link clock running at a fixed
// multiple of the serial bit rate.
package sop_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int          SOP_LANES        = 4;
    localparam int          SOP_ADC_BITS     = 10;
    localparam int          SOP_WORD_BITS    = 14;

    // ****************************************
    // Register map (byte wide registers)
    // ****************************************
    localparam logic [7:0]  SOP_ADDR_U1A     = 8'h19;
    localparam logic [7:0]  SOP_ADDR_U1B     = 8'h1a;
    localparam logic [7:0]  SOP_ADDR_U2A     = 8'h1b;
    localparam logic [7:0]  SOP_ADDR_U2B     = 8'h1c;
    localparam logic [7:0]  SOP_USER_RST     = 8'h00;

    // ****************************************
    // Resolution codes and word lengths
    // ****************************************
    localparam logic [1:0]  SOP_RES_10       = 2'h0;
    localparam logic [1:0]  SOP_RES_8        = 2'h1;
    localparam logic [1:0]  SOP_RES_12       = 2'h2;
    localparam logic [1:0]  SOP_RES_14       = 2'h3;
    localparam logic [3:0]  SOP_LEN_8        = 4'h8;
    localparam logic [3:0]  SOP_LEN_10       = 4'ha;
    localparam logic [3:0]  SOP_LEN_12       = 4'hc;
    localparam logic [3:0]  SOP_LEN_14       = 4'he;

    // ****************************************
    // Test modes
    // ****************************************
    typedef enum logic [3:0] {
        SOP_MODE_OFF     = 4'h0,
        SOP_MODE_MID     = 4'h1,
        SOP_MODE_FS_POS  = 4'h2,
        SOP_MODE_FS_NEG  = 4'h3,
        SOP_MODE_CHECKER = 4'h4,
        SOP_MODE_PRBS_LG = 4'h5,
        SOP_MODE_PRBS_SH = 4'h6,
        SOP_MODE_WORD_TG = 4'h7,
        SOP_MODE_USER    = 4'h8,
        SOP_MODE_BIT_TG  = 4'h9,
        SOP_MODE_SYNC    = 4'ha,
        SOP_MODE_ONE_HI  = 4'hb,
        SOP_MODE_MIXED   = 4'hc
    } sop_mode_e;

    // ****************************************
    // Pattern words
    // ****************************************
    localparam logic [13:0] SOP_CHECKER      = 14'h2aaa;
    localparam logic [13:0] SOP_MIX_8        = 14'h00a3;
    localparam logic [13:0] SOP_MIX_10       = 14'h0263;
    localparam logic [13:0] SOP_MIX_12       = 14'h0a33;
    localparam logic [13:0] SOP_MIX_14       = 14'h2867;
    localparam logic [8:0]  SOP_PRBS_SH_SEED = 9'h0df;
    localparam logic [22:0] SOP_PRBS_LG_SEED = 23'h0a6e02;
    localparam int          SOP_PRBS_SH_TAP  = 4;
    localparam int          SOP_PRBS_LG_TAP  = 17;

    // ****************************************
    // Link timing, in link clock ticks; bits per sample and rate limits
    // ****************************************
    localparam int          SOP_TICKS_BIT    = 6;
    localparam int          SOP_BCLK_TICKS   = 2 * SOP_TICKS_BIT;
    localparam int          SOP_PH_DEF_TICKS = 3;
    localparam int          SOP_PH_STEP_TCK  = 2;
    localparam int          SOP_BITS_SAMPLE  = 10;
    localparam int          SOP_MAX_KBPS     = 650000;
    localparam int          SOP_MIN_KSPS     = 10000;
    localparam int          SOP_MIN_KSPS_LOW = 5000;
    localparam int          SOP_CLK_KHZ      = 25000;

    // ****************************************
    // Carriers
    // ****************************************
    typedef logic [SOP_LANES-1:0][SOP_WORD_BITS-1:0] sop_lanes_t;
    typedef logic [SOP_LANES-1:0][SOP_ADC_BITS-1:0]  sop_samples_t;

    typedef struct packed {
        logic [1:0] res;
        sop_lanes_t lanes;
    } sop_word_s;

    typedef struct packed {
        sop_mode_e  mode;
        logic       invert;
        logic       lsb_first;
        logic       twos;
        logic [1:0] res;
        logic [2:0] phase;
        logic       low_rate;
    } sop_cfg_s;

endpackage

// ===== tb/sop_rx_model.sv
// Capture receiver model: double-data-rate capture of the four lanes.
// Assumes bit clock edges sit inside each bit and the frame clock rises with bit 0.
`timescale 1ns/1ps

module sop_rx_model
    import sop_pkg::*;
(
    // Link pins
    input  wire logic [SOP_LANES-1:0] lane,
    input  wire logic                 bclk,
    input  wire logic                 frame,
    // Captured words, right aligned
    output sop_pkg::sop_lanes_t       words,
    output logic [3:0]                len,
    output int unsigned               count
);
    // ****************************************
    // Capture
    // ****************************************
    sop_lanes_t  sh_q;
    logic [3:0]  n_q = 4'h0;
    logic        fr_q = 1'b0;
    wire         start = frame && !fr_q;
    initial count = 0;
    // A word is published when the next frame starts, so its length is known
    always @(posedge bclk or negedge bclk) begin
        for (int i = 0; i < SOP_LANES; i++) begin
            sh_q[i] <= start ? 14'(lane[i]) : {sh_q[i][12:0], lane[i]};
        end
        if (start && n_q != 4'h0) begin
            words <= sh_q;
            len <= n_q;
            count <= count + 1;
        end
        n_q <= start ? 4'h1 : n_q + 4'h1;
        fr_q <= frame;
    end
endmodule

// ===== tb/serial_output_test_patterns_bench.sv
// Bench for the serial output stage: registers, sample formats, test patterns.
// Assumes sop_rx_model as the receiver and the default bit clock phase.
`timescale 1ns/1ps

module serial_output_test_patterns_bench;
    import sop_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic                 clk, nrst, link_clk, reg_we, rate_ok, bcp, fcp;
    logic [7:0]           reg_addr, reg_wdata, reg_rdata;
    sop_samples_t         samples;
    sop_cfg_s             cfg;
    logic [SOP_LANES-1:0] lane_pos;
    sop_lanes_t           words;
    logic [3:0]           len;
    int unsigned          count;
    int                   miscompares = 0;
    int                   cmp_count = 0;
    sop_serial_out #(.CLK_KHZ(SOP_CLK_KHZ)) sop_serial_out_i (.CLK(clk), .NRST(nrst), .SAMPLES(samples),
        .CFG(cfg), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RDATA(reg_rdata),
        .RATE_OK(rate_ok), .LINK_CLK(link_clk), .LANE_POS(lane_pos), .LANE_NEG(), .BIT_CLOCK_OUT_POS(bcp),
        .BIT_CLOCK_OUT_NEG(), .FRAME_CLOCK_OUT_POS(fcp), .FRAME_CLOCK_OUT_NEG());
    sop_rx_model sop_rx_model_i (.lane(lane_pos), .bclk(bcp), .frame(fcp), .words(words), .len(len), .count(count));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(string what, logic [13:0] exp, logic [13:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic frames(int n);
        int unsigned c0;
        c0 = count;
        for (int k = 0; k < 5000 && count < c0 + n; k++) @(posedge clk);
        if (count < c0 + n) begin
            miscompares++;
            $display("[ERR] frames expected %0d seen %0d", n, count - c0);
            final_report();
        end
    endtask
    // Config only takes hold at a word boundary, so a few words are discarded
    task automatic setup(sop_mode_e m, logic [1:0] r, logic inv, logic lsb, logic tw);
        @(posedge clk);
        cfg <= '{m, inv, lsb, tw, r, 3'h0, 1'b0};
        frames(3);
    endtask
    function automatic logic [3:0] ln(logic [1:0] r);
        return (r == SOP_RES_8) ? SOP_LEN_8 : (r == SOP_RES_12) ? SOP_LEN_12 : (r == SOP_RES_14) ? SOP_LEN_14 : SOP_LEN_10;
    endfunction
    function automatic logic [13:0] fmt(logic [13:0] w, logic [3:0] n, logic inv, logic lsb);
        logic [13:0] o;
        o = 14'h0;
        for (int b = 0; b < n; b++) o[b] = (lsb ? w[n - 1 - b] : w[b]) ^ inv;
        return o;
    endfunction
    task automatic reg_write(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic reg_read(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 check("register", 14'(exp), 14'(reg_rdata));
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        reg_read(SOP_ADDR_U1A, SOP_USER_RST);
        check("rate ok", 14'h1, 14'(rate_ok));
        reg_write(SOP_ADDR_U1A, 8'ha5);
        reg_write(SOP_ADDR_U1B, 8'hc3);
        reg_write(SOP_ADDR_U2A, 8'h3c);
        reg_write(SOP_ADDR_U2B, 8'h81);
        reg_write(8'h1d, 8'h77);
        reg_read(SOP_ADDR_U1B, 8'hc3);
        reg_read(SOP_ADDR_U2B, 8'h81);
        reg_read(8'h1d, 8'h00);
    endtask
    task automatic t_data();
        logic [4:0]  tab [7] = '{5'h00, 5'h02, 5'h04, 5'h01, 5'h08, 5'h10, 5'h18};
        logic [13:0] w;
        logic [3:0]  n;
        for (int c = 0; c < 7; c++) begin
            setup(SOP_MODE_OFF, tab[c][4:3], tab[c][2], tab[c][1], tab[c][0]);
            n = ln(tab[c][4:3]);
            check("word length", 14'(n), 14'(len));
            for (int i = 0; i < SOP_LANES; i++) begin
                w = 14'(samples[i] ^ {tab[c][0], 9'h0});
                w = (n == SOP_LEN_8) ? w >> 2 : w << (n - SOP_LEN_10);
                check("lane data", fmt(w, n, tab[c][2], tab[c][1]), words[i]);
            end
        end
    endtask
    // Entries are {twos, mode, res, word}
    task automatic t_fixed();
        logic [20:0] tab [18] = '{21'h010200, 21'h0203ff, 21'h030000, 21'h0902aa, 21'h0b0200, 21'h0a400f,
            21'h0a001f, 21'h0a803f, 21'h0ac07f, 21'h0c40a3, 21'h0c0263, 21'h0c8a33, 21'h0ce867, 21'h09eaaa,
            21'h0b8800, 21'h1b0200, 21'h110000, 21'h1201ff};
        for (int c = 0; c < 18; c++) begin
            setup(sop_mode_e'(tab[c][19:16]), tab[c][15:14], 1'b0, 1'b0, tab[c][20]);
            check("word length", 14'(ln(tab[c][15:14])), 14'(len));
            for (int i = 0; i < SOP_LANES; i++) check("pattern", tab[c][13:0], words[i]);
        end
    endtask
    // Twos complement is set: these patterns must ignore it
    task automatic t_alt(sop_mode_e m, logic [1:0] r, logic [13:0] a, logic [13:0] b);
        logic [1:0] seen;
        seen = 2'b00;
        setup(m, r, 1'b0, 1'b0, 1'b1);
        for (int f = 0; f < 6; f++) begin
            frames(1);
            seen |= {words[0] === b, words[0] === a};
            check("alternating word", (words[0] === a) ? a : b, words[0]);
            check("lane match", words[0], words[SOP_LANES - 1]);
        end
        check("both words seen", 14'h3, 14'(seen));
    endtask
    // Pseudorandom words must keep moving and stay inside ten bits
    task automatic t_prbs(sop_mode_e m);
        logic [13:0] w;
        setup(m, SOP_RES_10, 1'b0, 1'b0, 1'b0);
        w = words[0];
        frames(1);
        check("prbs moves", 14'h1, 14'(w != words[0]));
        check("prbs width", 14'h0, words[1] & 14'h3c00);
    endtask
    // ****************************************
    // Clocks and main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    initial begin
        nrst = 1'b0;
        reg_we = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        samples = {10'h1fe, 10'h201, 10'h05a, 10'h3a5};
        cfg = '{SOP_MODE_OFF, 1'b0, 1'b0, 1'b0, SOP_RES_10, 3'h0, 1'b0};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_data();
        t_fixed();
        t_alt(SOP_MODE_CHECKER, SOP_RES_10, 14'h2aa, 14'h155);
        t_alt(SOP_MODE_WORD_TG, SOP_RES_14, 14'h3fff, 14'h0000);
        t_alt(SOP_MODE_USER, SOP_RES_10, 14'h297, 14'h0f2);
        t_alt(SOP_MODE_USER, SOP_RES_12, 14'ha5c, 14'h3c8);
        t_prbs(SOP_MODE_PRBS_SH);
        t_prbs(SOP_MODE_PRBS_LG);
        final_report();
    end
endmodule
